/* File: rtl/rfi_pkg.sv */
// Constants and types for the regulator fault interrupt register block
// Behaviour
// [R1] Mask bit 3 of the register at 0x06 masks the thermal source when 1, and the register resets to 0x00.
// [R2] Mask bit 2 masks the power-good source when 1, unmasks it when 0, and resets to 0.
// [R3] Mask bit 1 masks the overvoltage source when 1, unmasks it when 0, and resets to 0.
// [R4] Mask bit 0 masks the overcurrent source when 1, unmasks it when 0, and resets to 0.
// [R5] Flag bit 3 of the register at 0x07 is set when the thermal shutdown state rises from 0 to 1.
// [R6] Flag bit 2 is set when the active-low power-good signal falls from 1 to 0.
// [R7] Flag bit 1 is set when the overvoltage state rises from 0 to 1.
// [R8] Flag bit 0 is set when the overcurrent state rises from 0 to 1.
// [R9] A flag is left unchanged when its source holds still or moves the other way.
// [R10] Reading the flag register returns the flags and clears them; bits 7 to 4 read zero, ignore writes.
// [R11] The interrupt output is active while any flag is set whose mask bit is 0.
package rfi_pkg;

    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned SRC_N       = 4;

    localparam logic [7:0]  ADDR_MASK   = 8'h06;
    localparam logic [7:0]  ADDR_FLAGS  = 8'h07;

    localparam int unsigned BIT_THERMAL = 3;
    localparam int unsigned BIT_PGOOD   = 2;
    localparam int unsigned BIT_OVERV   = 1;
    localparam int unsigned BIT_OVERC   = 0;

    localparam logic [3:0]  MASK_RST    = 4'h0;
    localparam logic [3:0]  FLAGS_RST   = 4'h0;
    localparam logic [3:0]  COND_RST    = 4'h0;
    localparam logic [3:0]  RSVD_READ   = 4'h0;
    localparam logic [7:0]  RDATA_RST   = 8'h00;

    // Field order puts each source at its own register bit position
    typedef struct packed {
        logic thermal_shutdown_state;
        logic power_good_n;
        logic overvoltage_state;
        logic overcurrent_state;
    } rfi_cond_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } rfi_reg_req_t;

    typedef struct packed {
        rfi_cond_t   sync1;
        rfi_cond_t   sync2;
        rfi_cond_t   prev;
        logic [3:0]  mask;
        logic [3:0]  flags;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        irq;
    } rfi_state_t;

endpackage

/* File: rtl/rfi_regs.sv */
// Fault interrupt mask and sticky flag registers of the regulator
`timescale 1ns/100ps
module rfi_regs (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    // Fault condition levels from the analog side
    input  wire rfi_pkg::rfi_cond_t    i_cond,
    // Register access from the serial interface logic
    input  wire rfi_pkg::rfi_reg_req_t i_reg,
    output logic [7:0]                 o_rd_data,
    output logic                       o_rd_valid,
    // Combined interrupt indication, active high
    output logic                       o_irq
);

    rfi_pkg::rfi_state_t st_reg;
    rfi_pkg::rfi_state_t st_next;

    logic [3:0]          set_vec;
    logic [3:0]          clr_vec;
    logic [3:0]          now_vec;
    logic [3:0]          was_vec;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction

    always_comb begin
        st_next = st_reg;
        now_vec = st_reg.sync2;
        was_vec = st_reg.prev;

        // Raw levels are asynchronous to this clock; only sync2 and its delayed copy prev feed logic
        st_next.sync1 = i_cond;
        st_next.sync2 = st_reg.sync1;
        st_next.prev  = st_reg.sync2;

        set_vec = 4'h0;
        set_vec[rfi_pkg::BIT_THERMAL] = now_vec[rfi_pkg::BIT_THERMAL]
                                      & ~was_vec[rfi_pkg::BIT_THERMAL]; // [R5]
        set_vec[rfi_pkg::BIT_PGOOD]   = ~now_vec[rfi_pkg::BIT_PGOOD]
                                      & was_vec[rfi_pkg::BIT_PGOOD]; // [R6]
        set_vec[rfi_pkg::BIT_OVERV]   = now_vec[rfi_pkg::BIT_OVERV]
                                      & ~was_vec[rfi_pkg::BIT_OVERV]; // [R7]
        set_vec[rfi_pkg::BIT_OVERC]   = now_vec[rfi_pkg::BIT_OVERC]
                                      & ~was_vec[rfi_pkg::BIT_OVERC]; // [R8]

        clr_vec = 4'h0;
        st_next.rvalid = i_reg.rd;
        st_next.rdata  = rfi_pkg::RDATA_RST;
        if (i_reg.rd) begin
            if (hit(i_reg.addr, rfi_pkg::ADDR_MASK)) begin
                st_next.rdata = {rfi_pkg::RSVD_READ, st_reg.mask}; // [R10]
            end else if (hit(i_reg.addr, rfi_pkg::ADDR_FLAGS)) begin
                st_next.rdata = {rfi_pkg::RSVD_READ, st_reg.flags}; // [R10]
                clr_vec       = 4'hF;
            end
        end

        // Upper data bits are dropped so reserved bits stay zero
        if (i_reg.wr && hit(i_reg.addr, rfi_pkg::ADDR_MASK)) begin
            st_next.mask = i_reg.wdata[3:0]; // [R1] [R2] [R3] [R4]
        end

        // An edge landing in the clearing read survives to the next read
        st_next.flags = (st_reg.flags & ~clr_vec) | set_vec; // [R9] [R10]

        st_next.irq = |(st_next.flags & ~st_next.mask); // [R11]
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_reg.sync1  <= rfi_pkg::COND_RST;
            st_reg.sync2  <= rfi_pkg::COND_RST;
            st_reg.prev   <= rfi_pkg::COND_RST;
            st_reg.mask   <= rfi_pkg::MASK_RST; // [R1]
            st_reg.flags  <= rfi_pkg::FLAGS_RST;
            st_reg.rdata  <= rfi_pkg::RDATA_RST;
            st_reg.rvalid <= 1'b0;
            st_reg.irq    <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_rd_data  = st_reg.rdata;
    assign o_rd_valid = st_reg.rvalid;
    assign o_irq      = st_reg.irq;

    // Mask register writes land one cycle after the request

    AST_MASK_THERMAL: assert property (@(posedge i_clk) disable iff (i_rst) // [R1]
        (i_reg.wr && i_reg.addr == 8'h06)
        |=> st_reg.mask[3] == $past(i_reg.wdata[3]))
        else $error("thermal mask bit did not take the written value");

    AST_MASK_PGOOD: assert property (@(posedge i_clk) disable iff (i_rst) // [R2]
        (i_reg.wr && i_reg.addr == 8'h06)
        |=> st_reg.mask[2] == $past(i_reg.wdata[2]))
        else $error("power-good mask bit did not take the written value");

    AST_MASK_OVERV: assert property (@(posedge i_clk) disable iff (i_rst) // [R3]
        (i_reg.wr && i_reg.addr == 8'h06)
        |=> st_reg.mask[1] == $past(i_reg.wdata[1]))
        else $error("overvoltage mask bit did not take the written value");

    AST_MASK_OVERC: assert property (@(posedge i_clk) disable iff (i_rst) // [R4]
        (i_reg.wr && i_reg.addr == 8'h06)
        |=> st_reg.mask[0] == $past(i_reg.wdata[0]))
        else $error("overcurrent mask bit did not take the written value");

    AST_MASK_HOLD: assert property (@(posedge i_clk) disable iff (i_rst) // [R1]
        !(i_reg.wr && i_reg.addr == 8'h06) |=> $stable(st_reg.mask))
        else $error("mask changed without a mask write");

    AST_MASK_READ: assert property (@(posedge i_clk) disable iff (i_rst) // [R1]
        (i_reg.rd && i_reg.addr == 8'h06)
        |=> o_rd_valid && o_rd_data == {4'h0, $past(st_reg.mask)})
        else $error("mask read returned the wrong value");

    // Each source edge is seen three cycles after it reaches the pin

    AST_THERMAL_RISE: assert property (@(posedge i_clk) disable iff (i_rst) // [R5]
        (st_reg.sync2.thermal_shutdown_state && !st_reg.prev.thermal_shutdown_state)
        |=> st_reg.flags[3])
        else $error("thermal rise did not set its flag");

    AST_PGOOD_FALL: assert property (@(posedge i_clk) disable iff (i_rst) // [R6]
        (!st_reg.sync2.power_good_n && st_reg.prev.power_good_n)
        |=> st_reg.flags[2])
        else $error("power-good fall did not set its flag");

    AST_OVERV_RISE: assert property (@(posedge i_clk) disable iff (i_rst) // [R7]
        (st_reg.sync2.overvoltage_state && !st_reg.prev.overvoltage_state)
        |=> st_reg.flags[1])
        else $error("overvoltage rise did not set its flag");

    AST_OVERC_RISE: assert property (@(posedge i_clk) disable iff (i_rst) // [R8]
        (st_reg.sync2.overcurrent_state && !st_reg.prev.overcurrent_state)
        |=> st_reg.flags[0])
        else $error("overcurrent rise did not set its flag");

    AST_PIN_TO_FLAG: assert property (@(posedge i_clk) disable iff (i_rst) // [R8]
        (!i_reg.rd && !i_cond.overcurrent_state
         ##1 !i_reg.rd && i_cond.overcurrent_state ##1 !i_reg.rd ##1 !i_reg.rd)
        |=> st_reg.flags[0])
        else $error("overcurrent pin rise missed its flag");

    AST_NO_SPURIOUS: assert property (@(posedge i_clk) disable iff (i_rst) // [R9]
        ((st_reg.flags & ~$past(st_reg.flags)) & ~$past(set_vec)) == 4'h0)
        else $error("flag set without a qualifying edge");

    AST_THERMAL_FALL: assert property (@(posedge i_clk) disable iff (i_rst) // [R9]
        (!st_reg.sync2.thermal_shutdown_state && !st_reg.flags[3] && !i_reg.rd)
        |=> !st_reg.flags[3])
        else $error("thermal fall or hold set its flag");

    AST_READ_CLEAR: assert property (@(posedge i_clk) disable iff (i_rst) // [R10]
        (i_reg.rd && i_reg.addr == 8'h07)
        |=> o_rd_valid && o_rd_data == {4'h0, $past(st_reg.flags)}
            && st_reg.flags == $past(set_vec))
        else $error("flag read did not return and clear the flags");

    AST_FLAGS_HOLD: assert property (@(posedge i_clk) disable iff (i_rst) // [R10]
        !(i_reg.rd && i_reg.addr == 8'h07)
        |=> (st_reg.flags & $past(st_reg.flags)) == $past(st_reg.flags))
        else $error("flag lost without a flag read");

    AST_RSVD_ZERO: assert property (@(posedge i_clk) disable iff (i_rst) // [R10]
        o_rd_data[7:4] == 4'h0)
        else $error("reserved bits read nonzero");

    AST_IRQ_LEVEL: assert property (@(posedge i_clk) disable iff (i_rst) // [R11]
        o_irq == |(st_reg.flags & ~st_reg.mask))
        else $error("interrupt level disagrees with flags and mask");

    AST_IRQ_MASKED: assert property (@(posedge i_clk) disable iff (i_rst) // [R11]
        (st_reg.mask == 4'hF) |-> !o_irq)
        else $error("interrupt active with every source masked");

    // First edge after reset release still shows the reset values

    AST_RST_MASK: assert property (@(posedge i_clk) // [R1]
        $fell(i_rst) |-> st_reg.mask == rfi_pkg::MASK_RST)
        else $error("mask not at its reset value after reset");

    AST_RST_FLAGS: assert property (@(posedge i_clk) // [R10]
        $fell(i_rst) |-> st_reg.flags == rfi_pkg::FLAGS_RST)
        else $error("flags not clear after reset");

    AST_RST_READ: assert property (@(posedge i_clk) // [R10]
        $fell(i_rst) |-> !o_rd_valid && o_rd_data == rfi_pkg::RDATA_RST)
        else $error("read port not idle after reset");

    AST_RST_IRQ: assert property (@(posedge i_clk) // [R11]
        $fell(i_rst) |-> !o_irq)
        else $error("interrupt active after reset");

    AST_PIN_TO_THERMAL: assert property (@(posedge i_clk) disable iff (i_rst) // [R5]
        (!i_reg.rd && !i_cond.thermal_shutdown_state
         ##1 !i_reg.rd && i_cond.thermal_shutdown_state ##1 !i_reg.rd ##1 !i_reg.rd)
        |=> st_reg.flags[3])
        else $error("thermal pin rise missed its flag");

    AST_PIN_TO_PGOOD: assert property (@(posedge i_clk) disable iff (i_rst) // [R6]
        (!i_reg.rd && i_cond.power_good_n
         ##1 !i_reg.rd && !i_cond.power_good_n ##1 !i_reg.rd ##1 !i_reg.rd)
        |=> st_reg.flags[2])
        else $error("power-good pin fall missed its flag");

    AST_PIN_TO_OVERV: assert property (@(posedge i_clk) disable iff (i_rst) // [R7]
        (!i_reg.rd && !i_cond.overvoltage_state
         ##1 !i_reg.rd && i_cond.overvoltage_state ##1 !i_reg.rd ##1 !i_reg.rd)
        |=> st_reg.flags[1])
        else $error("overvoltage pin rise missed its flag");

    // Moves the wrong way, and levels that hold still, must leave flags alone

    AST_PGOOD_RISE: assert property (@(posedge i_clk) disable iff (i_rst) // [R9]
        (st_reg.sync2.power_good_n && !st_reg.flags[2] && !i_reg.rd)
        |=> !st_reg.flags[2])
        else $error("power-good rise or hold set its flag");

    AST_OVERV_FALL: assert property (@(posedge i_clk) disable iff (i_rst) // [R9]
        (!st_reg.sync2.overvoltage_state && !st_reg.flags[1] && !i_reg.rd)
        |=> !st_reg.flags[1])
        else $error("overvoltage fall or hold set its flag");

    AST_OVERC_FALL: assert property (@(posedge i_clk) disable iff (i_rst) // [R9]
        (!st_reg.sync2.overcurrent_state && !st_reg.flags[0] && !i_reg.rd)
        |=> !st_reg.flags[0])
        else $error("overcurrent fall or hold set its flag");

    AST_STEADY_QUIET: assert property (@(posedge i_clk) disable iff (i_rst) // [R9]
        (st_reg.sync2 == st_reg.prev && st_reg.flags == 4'h0)
        |=> st_reg.flags == 4'h0)
        else $error("flag set while every source held still");

    // Each flag stands until a read of the flag register

    AST_THERMAL_STICKY: assert property (@(posedge i_clk) disable iff (i_rst) // [R5]
        (st_reg.flags[3] && !(i_reg.rd && i_reg.addr == rfi_pkg::ADDR_FLAGS))
        |=> st_reg.flags[3])
        else $error("thermal flag dropped without a flag read");

    AST_PGOOD_STICKY: assert property (@(posedge i_clk) disable iff (i_rst) // [R6]
        (st_reg.flags[2] && !(i_reg.rd && i_reg.addr == rfi_pkg::ADDR_FLAGS))
        |=> st_reg.flags[2])
        else $error("power-good flag dropped without a flag read");

    AST_OVERV_STICKY: assert property (@(posedge i_clk) disable iff (i_rst) // [R7]
        (st_reg.flags[1] && !(i_reg.rd && i_reg.addr == rfi_pkg::ADDR_FLAGS))
        |=> st_reg.flags[1])
        else $error("overvoltage flag dropped without a flag read");

    AST_OVERC_STICKY: assert property (@(posedge i_clk) disable iff (i_rst) // [R8]
        (st_reg.flags[0] && !(i_reg.rd && i_reg.addr == rfi_pkg::ADDR_FLAGS))
        |=> st_reg.flags[0])
        else $error("overcurrent flag dropped without a flag read");

    // Every read strobe gets exactly one answer cycle, unmapped ones read zero

    AST_READ_ANSWER: assert property (@(posedge i_clk) disable iff (i_rst) // [R10]
        i_reg.rd
        |=> o_rd_valid)
        else $error("read got no answer");

    AST_VALID_PULSE: assert property (@(posedge i_clk) disable iff (i_rst) // [R10]
        !i_reg.rd
        |=> !o_rd_valid)
        else $error("read answer without a read");

    AST_RDATA_IDLE: assert property (@(posedge i_clk) disable iff (i_rst) // [R10]
        !i_reg.rd
        |=> o_rd_data == rfi_pkg::RDATA_RST)
        else $error("read data not idle without a read");

    AST_UNMAPPED_READ: assert property (@(posedge i_clk) disable iff (i_rst) // [R10]
        (i_reg.rd && i_reg.addr != rfi_pkg::ADDR_MASK && i_reg.addr != rfi_pkg::ADDR_FLAGS)
        |=> o_rd_valid && o_rd_data == rfi_pkg::RDATA_RST)
        else $error("unmapped read returned data");

    // Any unmasked flag drives the interrupt; a clean clearing read drops it

    AST_IRQ_THERMAL: assert property (@(posedge i_clk) disable iff (i_rst) // [R11]
        (st_reg.flags[3] && !st_reg.mask[3])
        |-> o_irq)
        else $error("unmasked thermal flag without interrupt");

    AST_IRQ_PGOOD: assert property (@(posedge i_clk) disable iff (i_rst) // [R11]
        (st_reg.flags[2] && !st_reg.mask[2])
        |-> o_irq)
        else $error("unmasked power-good flag without interrupt");

    AST_IRQ_OVERV: assert property (@(posedge i_clk) disable iff (i_rst) // [R11]
        (st_reg.flags[1] && !st_reg.mask[1])
        |-> o_irq)
        else $error("unmasked overvoltage flag without interrupt");

    AST_IRQ_OVERC: assert property (@(posedge i_clk) disable iff (i_rst) // [R11]
        (st_reg.flags[0] && !st_reg.mask[0])
        |-> o_irq)
        else $error("unmasked overcurrent flag without interrupt");

    AST_IRQ_CLEAR: assert property (@(posedge i_clk) disable iff (i_rst) // [R11]
        (i_reg.rd && i_reg.addr == rfi_pkg::ADDR_FLAGS && set_vec == 4'h0)
        |=> !o_irq)
        else $error("interrupt stayed active after clearing read");

endmodule

/* File: sim/rfi_host_model.sv */
// Host side model issuing register strobes to the fault interrupt block
`timescale 1ns/100ps
module rfi_host_model (
    // Clock
    input  wire logic             i_clk,
    // Register strobes and read answer
    output rfi_pkg::rfi_reg_req_t o_reg,
    input  wire logic [7:0]       i_rd_data,
    input  wire logic             i_rd_valid
);
    initial o_reg = '0;
    // One strobe cycle, then the answer is taken while it stands
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wd,
                          output logic [7:0] rd, output logic ok);
        @(negedge i_clk);
        o_reg = {wr, ~wr, addr, wd};
        @(negedge i_clk);
        o_reg = '0;
        ok = i_rd_valid;
        rd = i_rd_data;
    endtask
endmodule

/* File: sim/rfi_regs_tb.sv */
// Self-checking bench for the fault interrupt register block
`timescale 1ns/100ps
module rfi_regs_tb;
    localparam logic [3:0] IDLE = 4'h4;
    logic                  i_clk = 1'b0;
    logic                  i_rst = 1'b1;
    rfi_pkg::rfi_cond_t    i_cond = rfi_pkg::rfi_cond_t'(IDLE);
    rfi_pkg::rfi_reg_req_t reg_req;
    logic [7:0]            rd_data;
    logic [7:0]            got;
    logic                  rd_valid;
    logic                  irq;
    logic                  ok;
    logic [31:0]           seed = 32'h58DF;
    logic [3:0]            msk;
    int                    n_fail = 0;
    int                    cmp_count = 0;
    always #2 i_clk = ~i_clk;
    rfi_regs dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_cond(i_cond), .i_reg(reg_req),
        .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_irq(irq));
    rfi_host_model host_u (.i_clk(i_clk), .o_reg(reg_req), .i_rd_data(rd_data),
        .i_rd_valid(rd_valid));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] exp_irq(input logic [3:0] f, input logic [3:0] m);
        return {7'h00, |(f & ~m)};
    endfunction
    task automatic final_report();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] act);
        cmp_count++;
        if (act !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, act);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        host_u.access(1'b0, a, 8'h00, got, ok);
        chk("rd_valid", 8'h01, {7'h00, ok});
        chk(what, exp, got);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.access(1'b1, a, d, got, ok);
    endtask
    // Four cycles covers the two sync stages plus the edge detector
    task automatic settle(input logic [3:0] c);
        @(negedge i_clk);
        i_cond = rfi_pkg::rfi_cond_t'(c);
        repeat (4) @(negedge i_clk);
    endtask
    initial begin
        repeat (5000) @(posedge i_clk);
        n_fail++;
        final_report();
    end
    initial begin
        repeat (6) @(negedge i_clk);
        i_rst = 1'b0;
        @(negedge i_clk);
        chk("irq", 8'h00, {7'h00, irq});
        rd(rfi_pkg::ADDR_MASK, 8'h00, "mask");
        rd(rfi_pkg::ADDR_FLAGS, 8'h00, "flags");
        // Clear before the source returns, so a wrong-way move would show up
        for (int b = 0; b < 4; b++) begin
            settle(IDLE ^ (4'h1 << b));
            chk("irq", 8'h01, {7'h00, irq});
            rd(rfi_pkg::ADDR_FLAGS, 8'h01 << b, "flags");
            chk("irq", 8'h00, {7'h00, irq});
            settle(IDLE);
            rd(rfi_pkg::ADDR_FLAGS, 8'h00, "flags");
        end
        // Every source masked: flags still latch, interrupt stays quiet
        wr(rfi_pkg::ADDR_MASK, 8'hFF);
        rd(rfi_pkg::ADDR_MASK, 8'h0F, "mask");
        settle(~IDLE);
        chk("irq", 8'h00, {7'h00, irq});
        settle(IDLE);
        rd(rfi_pkg::ADDR_FLAGS, 8'h0F, "flags");
        for (int k = 0; k < 8; k++) begin
            seed = xs(seed);
            msk = seed[3:0];
            wr(rfi_pkg::ADDR_MASK, seed[7:0]);
            rd(rfi_pkg::ADDR_MASK, {4'h0, msk}, "mask");
            settle(IDLE ^ seed[11:8]);
            chk("irq", exp_irq(seed[11:8], msk), {7'h00, irq});
            wr(rfi_pkg::ADDR_FLAGS, 8'hFF);
            rd(rfi_pkg::ADDR_FLAGS, {4'h0, seed[11:8]}, "flags");
            chk("irq", 8'h00, {7'h00, irq});
            settle(IDLE);
            rd(rfi_pkg::ADDR_FLAGS, 8'h00, "flags");
        end
        wr(8'h3C, 8'hFF);
        rd(8'h3C, 8'h00, "unmapped");
        rd(rfi_pkg::ADDR_MASK, {4'h0, msk}, "mask");
        // Mid-run reset with a mask set and a flag pending
        wr(rfi_pkg::ADDR_MASK, 8'h0A);
        settle(IDLE ^ 4'h1);
        settle(IDLE);
        chk("irq", 8'h01, {7'h00, irq});
        @(negedge i_clk);
        i_rst = 1'b1;
        repeat (2) @(negedge i_clk);
        i_rst = 1'b0;
        @(negedge i_clk);
        chk("irq", 8'h00, {7'h00, irq});
        rd(rfi_pkg::ADDR_MASK, 8'h00, "mask");
        rd(rfi_pkg::ADDR_FLAGS, 8'h00, "flags");
        final_report();
    end
endmodule
